// *** core/scdt_pkg.sv ***
package scdt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_RC_OSCILLATOR_TRIM     = 12'h000;
  localparam logic [11:0] ADDR_CLOCK_PRESCALE_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_ASYNC_TIMER_STATUS_REG = 12'h008;
  localparam logic [11:0] ADDR_CLOCK_STATUS           = 12'h00C;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PRESCALE_CHANGE_ENABLE_BIT = 7;
  localparam int PRESCALE_SELECT_LSB        = 0;
  localparam int PRESCALE_SELECT_W          = 4;
  localparam int TRIM_W                     = 8;
  localparam int TRIM_RANGE_BIT             = 7;
  localparam int ASYNC_TIMER_ENABLE_BIT     = 0;
  localparam int ASYNC_EXT_CLOCK_SELECT_BIT = 1;
  localparam int STATUS_ACTIVE_SELECT_LSB   = 0;
  localparam int STATUS_PENDING_BIT         = 4;
  localparam int STATUS_CLOCK_OUT_FUSE_BIT  = 5;
  localparam int STATUS_DIV8_FUSE_BIT       = 6;
  localparam int STATUS_TIMER_OSC_BIT       = 7;
  localparam int STATUS_TIMER_BYPASS_BIT    = 8;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] PRESCALE_UNLOCK_PATTERN = 8'h80;
  localparam logic [3:0] SELECT_RESET_PLAIN      = 4'h0;
  localparam logic [3:0] SELECT_RESET_DIV8       = 4'h3;
  localparam logic [3:0] SELECT_MAX_DEFINED      = 4'h8;
  localparam logic [2:0] CHANGE_WINDOW_CYCLES    = 3'h4;
  localparam logic [31:0] READ_ZERO              = 32'h0000_0000;

  typedef enum logic [1:0] {
    SCDT_SW_IDLE,
    SCDT_SW_PENDING
  } scdt_switch_type;

endpackage

// *** core/scdt_clock_control.sv ***
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps

// Functional notes
// (RULE1) programmed clock-out fuse drives system clock on pin, also during reset
// (RULE2) pin carries the prescaled clock, never the undivided source; at select 0 the pin shows half the source rate
// (RULE3) timer oscillator shares crystal pins, allowed only with internal RC source
// (RULE4) external clock on timer oscillator input needs external-clock select bit set
// (RULE5) prescaler divides I/O, converter, core and program-memory clocks alike
// (RULE6) division changes without glitch and no faster intermediate period
// (RULE7) new frequency takes effect after old period plus one or two new periods
// (RULE8) prescaler counter runs on undivided clock and is not software readable
// (RULE9) software first writes change-enable one with all other bits zero
// (RULE10) software writes select with change-enable zero within four cycles
// (RULE11) software keeps interrupts off during the two-step change
// (RULE12) change-enable sets only when all other written bits are zero
// (RULE13) change-enable clears four cycles after set or on select write
// (RULE14) rewriting set change-enable neither restarts window nor clears it
// (RULE15) reset select is 0000, or 0011 with divide-by-eight fuse programmed
// (RULE16) software may write any select value regardless of the fuse
// (RULE17) select n from 0 to 8 divides by two to the n; 9..15 reserved
// (RULE18) reset loads trim register with factory calibration value
// (RULE19) software trim writes reach the RC oscillator
// (RULE20) top trim bit picks low or high overlapping range
// (RULE21) low seven trim bits tune within range, zero lowest
// (RULE22) software keeps trim at or below 8.8 MHz during memory writes
// (RULE23) reserved select write keeps the previous division factor
module scdt_clock_control #(
  parameter int MAX_SELECT = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        clockOutFuse,
  input  wire logic        divideByEightFuse,
  input  wire logic [7:0]  factoryCalibration,
  input  wire logic        systemSourceIsRc,
  output logic             clockOutPin,
  output logic             clockOutPinOe,
  output logic             ioClockEn,
  output logic             converterClockEn,
  output logic             coreClockEn,
  output logic             programMemoryClockEn,
  output logic [7:0]       rcOscillatorTrim,
  output logic             timerOscEnable,
  output logic             timerOscBypass
);

  localparam int CNT_W = MAX_SELECT;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (MAX_SELECT < 1 || MAX_SELECT > int'(scdt_pkg::SELECT_MAX_DEFINED)) begin : g_bad_max
    $error("MAX_SELECT out of range");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] terminalOf(input logic [3:0] sel);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1};
    terminalOf = CNT_W'((one << sel) - one);
  endfunction

  function automatic logic [CNT_W-1:0] halfOf(input logic [3:0] sel);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1};
    halfOf = (sel == 4'h0) ? '0 : CNT_W'(one << (sel - 4'h1));
  endfunction

  function automatic logic isReserved(input logic [3:0] sel);
    isReserved = (sel > 4'(MAX_SELECT));
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic       clockOutFuseMeta;
  logic       clockOutFuseSync;
  logic       div8FuseMeta;
  logic       div8FuseSync;
  logic       srcRcMeta;
  logic       srcRcSync;
  logic [7:0] calMeta;
  logic [7:0] calSync;
  // not reset: the clock-out pin must keep working through reset
  always_ff @(posedge clk) begin
    clockOutFuseMeta <= clockOutFuse;
    clockOutFuseSync <= clockOutFuseMeta;
    div8FuseMeta     <= divideByEightFuse;
    div8FuseSync     <= div8FuseMeta;
    srcRcMeta        <= systemSourceIsRc;
    srcRcSync        <= srcRcMeta;
    calMeta          <= factoryCalibration;
    calSync          <= calMeta;
  end

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  logic busWrite;
  logic busSetup;
  logic hitTrim;
  logic hitPrescale;
  logic hitAsync;
  logic hitStatus;
  logic addrMapped;
  assign busSetup    = psel && !penable;
  assign busWrite    = psel && penable && pready && pwrite;
  assign hitTrim     = (paddr == scdt_pkg::ADDR_RC_OSCILLATOR_TRIM);
  assign hitPrescale = (paddr == scdt_pkg::ADDR_CLOCK_PRESCALE_CONTROL);
  assign hitAsync    = (paddr == scdt_pkg::ADDR_ASYNC_TIMER_STATUS_REG);
  assign hitStatus   = (paddr == scdt_pkg::ADDR_CLOCK_STATUS);
  assign addrMapped  = hitTrim || hitPrescale || hitAsync || hitStatus;
  logic       writePrescale;
  logic       unlockWrite;
  logic [3:0] writtenSelect;
  assign writePrescale = busWrite && hitPrescale;
  assign unlockWrite   = writePrescale && (pwdata[7:0] == scdt_pkg::PRESCALE_UNLOCK_PATTERN);
  assign writtenSelect = pwdata[scdt_pkg::PRESCALE_SELECT_LSB +: scdt_pkg::PRESCALE_SELECT_W];

  // ----------------------------------------------------------------
  // change-enable and its window
  // ----------------------------------------------------------------
  logic       changeEnable;
  logic [2:0] windowCount;
  logic       selectWrite;
  assign selectWrite = writePrescale && changeEnable && !pwdata[scdt_pkg::PRESCALE_CHANGE_ENABLE_BIT];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      changeEnable <= 1'b0;
      windowCount  <= '0;
    end else if (unlockWrite && !changeEnable) begin
      changeEnable <= 1'b1;                                   // [RULE12]
      windowCount  <= scdt_pkg::CHANGE_WINDOW_CYCLES - 3'h1;
    end else if (changeEnable) begin
      // a rewrite of the unlock pattern falls through here untouched
      if (selectWrite || windowCount == 3'h0) begin
        changeEnable <= 1'b0;                                 // [RULE13]
      end
      windowCount <= windowCount - 3'h1;                      // [RULE14]
    end
  end

  // ----------------------------------------------------------------
  // prescale select register
  // ----------------------------------------------------------------
  logic [3:0] prescaleSelect;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prescaleSelect <= div8FuseSync ? scdt_pkg::SELECT_RESET_DIV8 : scdt_pkg::SELECT_RESET_PLAIN; // [RULE15]
    end else if (selectWrite && !isReserved(writtenSelect)) begin
      prescaleSelect <= writtenSelect;                        // [RULE16] [RULE17] [RULE23]
    end
  end

  // ----------------------------------------------------------------
  // ripple prescaler on the undivided clock
  // ----------------------------------------------------------------
  scdt_pkg::scdt_switch_type switchState;
  logic [3:0]                activeSelect;
  logic [CNT_W-1:0]          divCount;
  logic [CNT_W-1:0]          next_divCount;
  logic [3:0]                next_activeSelect;
  logic                      periodEnd;
  // at least, so a count left by the reset toggle cannot run past a small terminal
  assign periodEnd = (divCount >= terminalOf(activeSelect));
  always_comb begin
    next_divCount     = periodEnd ? '0 : divCount + CNT_W'(1);
    // new factor only at a period boundary, so no period is ever cut short
    next_activeSelect = (periodEnd && switchState == scdt_pkg::SCDT_SW_PENDING) ? prescaleSelect : activeSelect;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switchState <= scdt_pkg::SCDT_SW_IDLE;
    end else begin
      case (switchState)
        scdt_pkg::SCDT_SW_IDLE: begin
          if (prescaleSelect != activeSelect) begin
            switchState <= scdt_pkg::SCDT_SW_PENDING;
          end
        end
        scdt_pkg::SCDT_SW_PENDING: begin
          if (periodEnd) begin
            switchState <= scdt_pkg::SCDT_SW_IDLE;
          end
        end
        default: begin
          switchState <= scdt_pkg::SCDT_SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      activeSelect <= div8FuseSync ? scdt_pkg::SELECT_RESET_DIV8 : scdt_pkg::SELECT_RESET_PLAIN;
    end else begin
      activeSelect <= next_activeSelect;                      // [RULE6] [RULE7]
    end
  end

  // during reset the counter keeps toggling so the pin still shows a clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCount <= (divCount == '0) ? CNT_W'(1) : '0;
    end else begin
      divCount <= next_divCount;                              // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // divided clock enables and pin level
  // ----------------------------------------------------------------
  logic systemTick;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      systemTick <= 1'b0;
    end else begin
      systemTick <= periodEnd;                                // [RULE5]
    end
  end

  assign ioClockEn            = systemTick;
  assign converterClockEn     = systemTick;
  assign coreClockEn          = systemTick;
  assign programMemoryClockEn = systemTick;

  // divide-by-one can only show half the source rate from a flop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clockOutPin <= (divCount == '0);
    end else if (next_activeSelect == 4'h0) begin
      clockOutPin <= !clockOutPin;
    end else begin
      clockOutPin <= (next_divCount < halfOf(next_activeSelect)); // [RULE2]
    end
  end

  always_ff @(posedge clk) begin
    clockOutPinOe <= clockOutFuseSync;                        // [RULE1]
  end

  // ----------------------------------------------------------------
  // RC trim register
  // ----------------------------------------------------------------
  // trim feeds the oscillator directly; range bit on top, steps below
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rcOscillatorTrim <= calSync;                            // [RULE18]
    end else if (busWrite && hitTrim) begin
      rcOscillatorTrim <= pwdata[scdt_pkg::TRIM_W-1:0];       // [RULE19] [RULE20] [RULE21]
    end
  end

  // ----------------------------------------------------------------
  // timer oscillator on the shared crystal pins
  // ----------------------------------------------------------------
  logic asyncTimerEnable;
  logic asyncExtClockSelect;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      asyncTimerEnable    <= 1'b0;
      asyncExtClockSelect <= 1'b0;
    end else if (busWrite && hitAsync) begin
      asyncTimerEnable    <= pwdata[scdt_pkg::ASYNC_TIMER_ENABLE_BIT];
      asyncExtClockSelect <= pwdata[scdt_pkg::ASYNC_EXT_CLOCK_SELECT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timerOscEnable <= 1'b0;
      timerOscBypass <= 1'b0;
    end else begin
      timerOscEnable <= asyncTimerEnable && srcRcSync;                        // [RULE3]
      timerOscBypass <= asyncTimerEnable && srcRcSync && asyncExtClockSelect; // [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = scdt_pkg::READ_ZERO;
    if (hitTrim) begin
      next_prdata[scdt_pkg::TRIM_W-1:0] = rcOscillatorTrim;
    end else if (hitPrescale) begin
      next_prdata[scdt_pkg::PRESCALE_CHANGE_ENABLE_BIT] = changeEnable;
      next_prdata[scdt_pkg::PRESCALE_SELECT_LSB +: scdt_pkg::PRESCALE_SELECT_W] = prescaleSelect;
    end else if (hitAsync) begin
      next_prdata[scdt_pkg::ASYNC_TIMER_ENABLE_BIT]     = asyncTimerEnable;
      next_prdata[scdt_pkg::ASYNC_EXT_CLOCK_SELECT_BIT] = asyncExtClockSelect;
    end else if (hitStatus) begin
      next_prdata[scdt_pkg::STATUS_ACTIVE_SELECT_LSB +: scdt_pkg::PRESCALE_SELECT_W] = activeSelect;
      next_prdata[scdt_pkg::STATUS_PENDING_BIT]        = (switchState == scdt_pkg::SCDT_SW_PENDING);
      next_prdata[scdt_pkg::STATUS_CLOCK_OUT_FUSE_BIT] = clockOutFuseSync;
      next_prdata[scdt_pkg::STATUS_DIV8_FUSE_BIT]      = div8FuseSync;
      next_prdata[scdt_pkg::STATUS_TIMER_OSC_BIT]      = timerOscEnable;
      next_prdata[scdt_pkg::STATUS_TIMER_BYPASS_BIT]   = timerOscBypass;
    end
  end

  // answer prepared in setup, so every access completes in one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= scdt_pkg::READ_ZERO;
    end else begin
      pready  <= busSetup;
      pslverr <= busSetup && !addrMapped;
      if (busSetup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [3:0] enableAge;
  always_ff @(posedge clk) begin
    if (!rst_b || !changeEnable) begin
      enableAge <= '0;
    end else begin
      enableAge <= enableAge + 4'h1;
    end
  end
  sequence s_unlockWhileSet;
    changeEnable && unlockWrite;
  endsequence
  sequence s_windowRunsDown;
    ##1 (!changeEnable || windowCount == $past(windowCount) - 3'h1);
  endsequence
  a_pce_guard_write: assert property (@(posedge clk) disable iff (!rst_b) // [RULE12]
    (writePrescale && !unlockWrite && !changeEnable) |=> !changeEnable)
    else $error("change enable set by a write with other bits nonzero");
  a_pce_window_end: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
    $rose(changeEnable) |-> ##[1:4] !changeEnable)
    else $error("change enable outlived its window");
  a_pce_age_bound: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
    enableAge <= 4'h4)
    else $error("change enable held too long");
  a_pce_no_restart: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
    s_unlockWhileSet |-> s_windowRunsDown)
    else $error("rewrite restarted the change window");
  a_select_reset_value: assert property (@(posedge clk) // [RULE15]
    (rst_b && !$past(rst_b)) |-> (prescaleSelect == ($past(div8FuseSync) ?
      scdt_pkg::SELECT_RESET_DIV8 : scdt_pkg::SELECT_RESET_PLAIN)))
    else $error("wrong select reset value");
  a_select_write_taken: assert property (@(posedge clk) disable iff (!rst_b) // [RULE16]
    (selectWrite && !isReserved(writtenSelect)) |=> prescaleSelect == $past(writtenSelect))
    else $error("select write not taken");
  a_select_reserved_kept: assert property (@(posedge clk) disable iff (!rst_b) // [RULE23]
    (selectWrite && isReserved(writtenSelect)) |=> $stable(prescaleSelect))
    else $error("reserved select changed the factor");
  a_switch_at_boundary: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
    ($past(rst_b) && $changed(activeSelect)) |-> $past(periodEnd))
    else $error("division changed mid period");
  a_switch_latency: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
    (switchState == scdt_pkg::SCDT_SW_PENDING) |-> ##[0:256] (activeSelect == prescaleSelect))
    else $error("new division never took effect");
  a_tick_period_end: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
    ($past(rst_b) && coreClockEn) |-> $past(periodEnd))
    else $error("clock enable off period boundary");
  a_pin_divided: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
    ($past(rst_b) && activeSelect != 4'h0) |-> (clockOutPin == (divCount < halfOf(activeSelect))))
    else $error("pin not the divided clock");
  a_pin_drive_fuse: assert property (@(posedge clk) // [RULE1]
    clockOutFuseSync |=> clockOutPinOe)
    else $error("clock out pin not driven");
  a_trim_write_taken: assert property (@(posedge clk) disable iff (!rst_b) // [RULE19]
    (busWrite && hitTrim) |=> rcOscillatorTrim == $past(pwdata[7:0]))
    else $error("trim write lost");
  a_trim_reset_load: assert property (@(posedge clk) // [RULE18]
    (rst_b && !$past(rst_b)) |-> rcOscillatorTrim == $past(calSync))
    else $error("trim not loaded with calibration");
  a_timer_osc_rc: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
    timerOscEnable |-> $past(srcRcSync))
    else $error("timer oscillator without RC source");
  a_timer_ext_clock: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
    timerOscBypass |-> $past(asyncExtClockSelect) && timerOscEnable)
    else $error("external clock without select bit");

endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps

module tb;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clockOutFuse;
  logic        divideByEightFuse;
  logic [7:0]  factoryCalibration;
  logic        systemSourceIsRc;
  logic        clockOutPin;
  logic        clockOutPinOe;
  logic        ioClockEn;
  logic        converterClockEn;
  logic        coreClockEn;
  logic        programMemoryClockEn;
  logic [7:0]  rcOscillatorTrim;
  logic        timerOscEnable;
  logic        timerOscBypass;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          comparisons;
  int          rises;
  int          pulses;
  int          bad;
  int          minGap;
  int          cur;
  localparam logic [11:0] PR = scdt_pkg::ADDR_CLOCK_PRESCALE_CONTROL;

  scdt_clock_control #(.MAX_SELECT(8)) uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clockOutFuse(clockOutFuse), .divideByEightFuse(divideByEightFuse), .factoryCalibration(factoryCalibration),
    .systemSourceIsRc(systemSourceIsRc), .clockOutPin(clockOutPin), .clockOutPinOe(clockOutPinOe),
    .ioClockEn(ioClockEn), .converterClockEn(converterClockEn), .coreClockEn(coreClockEn),
    .programMemoryClockEn(programMemoryClockEn), .rcOscillatorTrim(rcOscillatorTrim),
    .timerOscEnable(timerOscEnable), .timerOscBypass(timerOscBypass));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one idle cycle after each transfer keeps psel from being assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    check(n, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // counts pin rises, enable pulses, enable disagreement and the shortest pulse gap
  task automatic count(input int len);
    logic prev;
    int   last;
    prev = clockOutPin;
    last = -1;
    rises = 0;
    pulses = 0;
    bad = 0;
    minGap = 1000;
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      if (clockOutPin === 1'b1 && prev === 1'b0) rises++;
      prev = clockOutPin;
      if ({converterClockEn, coreClockEn, programMemoryClockEn} !== {3{ioClockEn}}) bad++;
      if (ioClockEn === 1'b1) begin
        pulses++;
        if (last >= 0 && i - last < minGap) minGap = i - last;
        last = i;
      end
    end
  endtask

  task automatic do_reset(input logic div8, input logic fuse);
    divideByEightFuse <= div8;
    clockOutFuse <= fuse;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    count(8);
    check(clockOutPinOe, fuse);
    check(rises, 4);
    rst_b <= 1'b1;
    @(posedge clk);
    cur = div8 ? 3 : 0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rdchk(PR, 32'h0000_0003);
    rdchk(scdt_pkg::ADDR_RC_OSCILLATOR_TRIM, 32'h0000_005A);
    check(rcOscillatorTrim, 8'h5A);
    rdchk(scdt_pkg::ADDR_CLOCK_STATUS, 32'h0000_0063);
  endtask

  task automatic t_trim();
    logic [7:0] v[4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
    foreach (v[i]) begin
      apb(1'b1, scdt_pkg::ADDR_RC_OSCILLATOR_TRIM, {24'h00_0000, v[i]});
      rdchk(scdt_pkg::ADDR_RC_OSCILLATOR_TRIM, {24'h00_0000, v[i]});
      check(rcOscillatorTrim, v[i]);
    end
  endtask

  task automatic t_divide(input int n);
    int pOld;
    int pNew;
    pOld = 1 << cur;
    pNew = 1 << n;
    apb(1'b1, PR, 32'h0000_0080);
    apb(1'b1, PR, n);
    rdchk(PR, n);
    count(pOld + 2 * pNew + 8);
    check(minGap >= (pOld < pNew ? pOld : pNew), 1'b1);
    count(4 * pNew);
    check(pulses, 4);
    check(rises, n == 0 ? 2 : 4);
    check(bad, 0);
    cur = n;
  endtask

  task automatic t_lock();
    apb(1'b1, PR, 32'h0000_0081);
    apb(1'b1, PR, 32'h0000_0002);
    rdchk(PR, cur);
    apb(1'b1, PR, 32'h0000_0080);
    apb(1'b1, PR, 32'h0000_0080);
    apb(1'b1, PR, 32'h0000_0002);
    rdchk(PR, cur);
    apb(1'b1, PR, 32'h0000_0080);
    rdchk(PR, 32'h0000_0080 | cur);
    apb(1'b1, PR, 32'h0000_0002);
    rdchk(PR, cur);
    apb(1'b1, PR, 32'h0000_0080);
    apb(1'b1, PR, 32'h0000_0009);
    rdchk(PR, cur);
  endtask

  task automatic t_async();
    systemSourceIsRc <= 1'b1;
    apb(1'b1, scdt_pkg::ADDR_ASYNC_TIMER_STATUS_REG, 32'h0000_0003);
    repeat (4) @(posedge clk);
    check({timerOscEnable, timerOscBypass}, 2'b11);
    apb(1'b1, scdt_pkg::ADDR_ASYNC_TIMER_STATUS_REG, 32'h0000_0001);
    repeat (4) @(posedge clk);
    check({timerOscEnable, timerOscBypass}, 2'b10);
    systemSourceIsRc <= 1'b0;
    repeat (6) @(posedge clk);
    check(timerOscEnable, 1'b0);
  endtask

  task automatic t_unmapped();
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    check(err, 1'b1);
    apb(1'b1, scdt_pkg::ADDR_CLOCK_STATUS, 32'hFFFF_FFFF);
    rdchk(PR, cur);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    $display("Error at %0t: watchdog expired", $time);
    num_errors++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    clockOutFuse = 1'b1;
    divideByEightFuse = 1'b1;
    factoryCalibration = 8'h5A;
    systemSourceIsRc = 1'b1;
    num_errors = 0;
    comparisons = 0;
    @(posedge clk);
    do_reset(1'b1, 1'b1);
    t_reset_values();
    t_trim();
    for (int n = 0; n <= 8; n++) t_divide(n);
    t_lock();
    t_async();
    t_unmapped();
    do_reset(1'b0, 1'b0);
    rdchk(PR, 32'h0000_0000);
    finish_test();
  end
endmodule
